//--- rtl/pfcs_regs.vh
`ifndef PFCS_REGS_VH
`define PFCS_REGS_VH
// ==========================================
// Register byte offsets
`define PFCS_OFS_STAT 5'h00
`define PFCS_OFS_PTR 5'h04
`define PFCS_OFS_DATA 5'h08
`define PFCS_OFS_DIV 5'h0C
// ==========================================
// Status and divider bit positions
`define PFCS_BIT_DONE 7
`define PFCS_BIT_ACC 5
`define PFCS_BIT_FPV 4
`define PFCS_BIT_VERR 1
`define PFCS_BIT_VFAT 0
`define PFCS_BIT_DIVLD 7
// ==========================================
// Commands, slots, limits
`define PFCS_CMD_EVS 8'h03
`define PFCS_CMD_ONCE 8'h04
`define PFCS_CMD_PROG 8'h06
`define PFCS_PTR_EVS 3'h2
`define PFCS_PTR_ONCE 3'h1
`define PFCS_PTR_PROG 3'h5
`define PFCS_ONCE_MAX 16'h0007
`define PFCS_PHR_128K 17'h0_4000
`define PFCS_PHR_STEP 23'h00_0008
`define PFCS_ERASED 64'hFFFF_FFFF_FFFF_FFFF
// ==========================================
// Reset values
`define PFCS_RST_PTR 3'h0
`define PFCS_RST_SLOT 16'h0000
`define PFCS_RST_DIV 7'h00
`endif

//--- rtl/pfcs_sequencer.v
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pfcs_regs.vh"
module pfcs_sequencer #(
  parameter [22:0] PF_BASE = 23'h60_0000,
  parameter [22:0] PF_TOP  = 23'h7F_FFFF
)(
  // Clock, reset, enable
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        ce,
  // AXI4-Lite write
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Mode and protection
  input  wire [2:0]  modeAllow,
  input  wire        protEnable,
  input  wire [22:0] protLo,
  input  wire [22:0] protHi,
  // Flash array port
  output wire        flashReq,
  output wire        flashWrite,
  output reg         flashInfo,
  output reg  [22:0] flashAddr,
  output wire [63:0] flashWdata,
  input  wire        flashAck,
  input  wire [63:0] flashRdata,
  input  wire        flashErr,
  input  wire        flashFatal,
  // Status
  output wire        blockReadInvalid
);

  // ==========================================
  // Sequencer states
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_RD   = 2'b01;
  localparam [1:0] S_WR   = 2'b10;
  localparam [1:0] S_VF   = 2'b11;

  // ==========================================
  // Declarations
  reg         awFull;
  reg  [4:0]  awAddr;
  reg         wFull;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg  [2:0]  ptr;
  reg         cmdDone;
  reg         access_error_flag;
  reg         protection_violation_flag;
  reg         verr;
  reg         vfat;
  reg         divLoaded;
  reg  [6:0]  divVal;
  reg  [1:0]  state;
  reg  [15:0] remain;
  reg  [31:0] rdMux;
  reg         rdOk;
  wire [95:0] slotBus;
  reg  [15:0] slotRd;

  // ==========================================
  // Register write decode
  wire        doWrite = awFull & wFull & ~s_axi_bvalid;
  wire [4:0]  wOfs    = {awAddr[4:2], 2'b00};
  wire        wStat   = doWrite & (wOfs == `PFCS_OFS_STAT) & wStrb[0];
  wire        wPtr    = doWrite & (wOfs == `PFCS_OFS_PTR) & wStrb[0];
  wire        wSlot   = doWrite & (wOfs == `PFCS_OFS_DATA);
  wire        wDiv    = doWrite & (wOfs == `PFCS_OFS_DIV) & wStrb[0];
  wire        wMapped = (wOfs <= `PFCS_OFS_DIV);
  wire        clrAcc  = wStat & wData[`PFCS_BIT_ACC];
  wire        clrFpv  = wStat & wData[`PFCS_BIT_FPV];
  // Launch is refused while the access error or protection violation flag is still pending
  wire        launch  = wStat & wData[`PFCS_BIT_DONE] & cmdDone & ~access_error_flag & ~protection_violation_flag;

  assign s_axi_awready = ce & ~awFull;
  assign s_axi_wready  = ce & ~wFull;
  assign s_axi_arready = ce & ~s_axi_rvalid;

  // ==========================================
  // Command decode and launch checks
  wire [15:0] s0 = slotBus[15:0];
  wire [15:0] s1 = slotBus[31:16];
  wire [15:0] s2 = slotBus[47:32];
  wire [7:0]  cmd = s0[15:8];
  wire [22:0] gAddr = {s0[6:0], s1};
  wire        isEvs  = (cmd == `PFCS_CMD_EVS);
  wire        isOnce = (cmd == `PFCS_CMD_ONCE);
  wire        isProg = (cmd == `PFCS_CMD_PROG);
  wire        usesAddr = isEvs | isProg;
  wire        badCmd = ~(isEvs | isOnce | isProg);
  wire        badPtr = (isEvs & (ptr != `PFCS_PTR_EVS))
                     | (isOnce & (ptr != `PFCS_PTR_ONCE))
                     | (isProg & (ptr != `PFCS_PTR_PROG));
  wire        badMode = (isEvs & ~modeAllow[0])
                      | (isOnce & ~modeAllow[1])
                      | (isProg & ~modeAllow[2]);
  wire        badDiv = isProg & ~divLoaded;
  wire        badAddr = usesAddr & ((gAddr < PF_BASE) | (gAddr > PF_TOP));
  wire        badAlign = usesAddr & (gAddr[2:0] != 3'b000);
  // Phrase position inside its 128 Kbyte window plus the count
  wire [16:0] crossSum = {3'b000, gAddr[16:3]} + {1'b0, s2};
  wire        badCross = isEvs & (crossSum > `PFCS_PHR_128K);
  wire        badIdx = isOnce & (s1 > `PFCS_ONCE_MAX);
  wire        accFail = badCmd | badPtr | badMode | badDiv
                      | badAddr | badAlign | badCross | badIdx;
  wire        protHit = isProg & protEnable
                      & (gAddr >= protLo) & (gAddr <= protHi);
  wire        chkFail = accFail | protHit;
  wire        emptyEvs = isEvs & (s2 == 16'h0000);
  wire        go = launch & ~chkFail & ~emptyEvs;

  // ==========================================
  // Sequencer outcome terms
  wire        ack     = ce & flashAck & (state != S_IDLE);
  wire        rdAck   = ack & (state == S_RD);
  wire        vfAck   = ack & (state == S_VF);
  wire        onceFill = rdAck & flashInfo;
  wire        rdBad   = flashErr | (~flashInfo & (flashRdata != `PFCS_ERASED));
  wire        vfBad   = flashErr | (flashRdata != flashWdata);
  wire        lastRd  = flashInfo | (remain == 16'h0001);
  wire        done    = (rdAck & lastRd) | vfAck;
  wire        setVerr = (rdAck & rdBad)
                      | (vfAck & vfBad)
                      | (ack & (state == S_WR) & flashErr);
  wire        setVfat = (rdAck | vfAck) & flashFatal;

  assign flashReq   = ce & (state != S_IDLE);
  assign flashWrite = (state == S_WR);
  assign flashWdata = slotBus[95:32];
  assign blockReadInvalid = ~cmdDone;

  // ==========================================
  // Command object slots
  wire slotEn = wSlot & cmdDone;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : gSlot
      reg  [15:0] val;
      wire [15:0] fillData;
      wire        fillEn;
      wire        sel = slotEn & ({29'h0000_0000, ptr} == gi);
      if (gi >= 2)
      begin : gFill
        assign fillData = flashRdata[(gi-2)*16 +: 16];
        assign fillEn   = onceFill;
      end
      else
      begin : gNoFill
        assign fillData = 16'h0000;
        assign fillEn   = 1'b0;
      end
      always @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
          val <= `PFCS_RST_SLOT;
        else if (ce)
        begin
          if (fillEn)
            val <= fillData;
          else
          begin
            if (sel & wStrb[0])
              val[7:0] <= wData[7:0];
            if (sel & wStrb[1])
              val[15:8] <= wData[15:8];
          end
        end
      end
      assign slotBus[gi*16 +: 16] = val;
    end
  endgenerate

  always @*
  begin
    case (ptr)
      3'h0: slotRd = slotBus[15:0];
      3'h1: slotRd = slotBus[31:16];
      3'h2: slotRd = slotBus[47:32];
      3'h3: slotRd = slotBus[63:48];
      3'h4: slotRd = slotBus[79:64];
      3'h5: slotRd = slotBus[95:80];
      default: slotRd = 16'h0000;
    endcase
  end

  // ==========================================
  // AXI4-Lite write channel
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      awFull       <= 1'b0;
      awAddr       <= 5'h00;
      wFull        <= 1'b0;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (ce)
    begin
      if (s_axi_awvalid & ~awFull)
      begin
        awFull <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~wFull)
      begin
        wFull <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awFull       <= 1'b0;
        wFull        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wMapped ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // AXI4-Lite read channel
  always @*
  begin
    rdOk  = 1'b1;
    rdMux = 32'h0000_0000;
    case ({s_axi_araddr[4:2], 2'b00})
      `PFCS_OFS_STAT: rdMux = {24'h00_0000, cmdDone, 1'b0, access_error_flag, protection_violation_flag, 2'b00, verr, vfat};
      `PFCS_OFS_PTR:  rdMux = {29'h0000_0000, ptr};
      `PFCS_OFS_DATA: rdMux = {16'h0000, slotRd};
      `PFCS_OFS_DIV:  rdMux = {24'h00_0000, divLoaded, divVal};
      default:        rdOk  = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else if (ce)
    begin
      if (s_axi_arvalid & ~s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdOk ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // Control registers and flags
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ptr       <= `PFCS_RST_PTR;
      divLoaded <= 1'b0;
      divVal    <= `PFCS_RST_DIV;
      cmdDone   <= 1'b1;
      access_error_flag    <= 1'b0;
      protection_violation_flag    <= 1'b0;
      verr      <= 1'b0;
      vfat      <= 1'b0;
    end
    else if (ce)
    begin
      // Setup writes are ignored while a command runs
      if (wPtr & cmdDone)
        ptr <= wData[2:0];
      if (wDiv & cmdDone)
      begin
        divVal    <= wData[6:0];
        divLoaded <= 1'b1;
      end
      // A set in the same cycle as a clear wins
      access_error_flag <= (access_error_flag & ~clrAcc) | (launch & accFail);
      protection_violation_flag <= (protection_violation_flag & ~clrFpv) | (launch & ~accFail & protHit);
      if (launch)
      begin
        verr <= 1'b0;
        vfat <= 1'b0;
      end
      else
      begin
        verr <= verr | setVerr;
        vfat <= vfat | setVfat;
      end
      if (go)
        cmdDone <= 1'b0;
      else if (done)
        cmdDone <= 1'b1;
    end
  end

  // ==========================================
  // Array sequencer
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state     <= S_IDLE;
      remain    <= 16'h0000;
      flashAddr <= 23'h00_0000;
      flashInfo <= 1'b0;
    end
    else if (ce)
    begin
      case (state)
        S_IDLE:
        begin
          if (go)
          begin
            remain <= s2;
            if (isOnce)
            begin
              // Once field sits in the block 0 information area
              flashInfo <= 1'b1;
              flashAddr <= {17'h0_0000, s1[2:0], 3'b000};
              state     <= S_RD;
            end
            else
            begin
              flashInfo <= 1'b0;
              flashAddr <= gAddr;
              state     <= isProg ? S_WR : S_RD;
            end
          end
        end
        S_RD:
        begin
          if (flashAck)
          begin
            if (lastRd)
              state <= S_IDLE;
            else
            begin
              remain    <= remain - 16'h0001;
              flashAddr <= flashAddr + `PFCS_PHR_STEP;
            end
          end
        end
        S_WR:
        begin
          if (flashAck)
            state <= S_VF;
        end
        S_VF:
        begin
          if (flashAck)
            state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

endmodule // pfcs_sequencer
`default_nettype wire

//--- verif/pfcs_sequencer_props.sv
`timescale 1ns/100ps
`default_nettype none
module pfcs_sequencer_props #(
  parameter [22:0] PF_BASE = 23'h60_0000,
  parameter [22:0] PF_TOP  = 23'h7F_FFFF
)(
  // Clock and reset
  input wire        clk_sys,
  input wire        nrst,
  // Bus and protection
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        protEnable,
  input wire [22:0] protLo,
  input wire [22:0] protHi,
  // Flash array port
  input wire        flashReq,
  input wire        flashWrite,
  input wire        flashInfo,
  input wire [22:0] flashAddr,
  input wire [63:0] flashWdata,
  input wire        flashAck,
  input wire        blockReadInvalid
);
  // ====
  // Checks
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  property p_arBlock;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arBlock: assert property (p_arBlock) else $error("read taken during answer");
  property p_reqHold;
    flashReq && !flashAck |=> flashReq;
  endproperty
  a_reqHold: assert property (p_reqHold) else $error("array request dropped early");
  property p_busy;
    flashReq |-> blockReadInvalid;
  endproperty
  a_busy: assert property (p_busy) else $error("array busy but reads valid");
  property p_done;
    $fell(blockReadInvalid) |-> $past(flashAck);
  endproperty
  a_done: assert property (p_done) else $error("complete without final ack");
  property p_readBack;
    flashReq && flashWrite && flashAck |=> flashReq && !flashWrite && $stable(flashAddr);
  endproperty
  a_readBack: assert property (p_readBack) else $error("no read-back after write");
  property p_wdata;
    flashWrite && !flashAck |=> flashWrite && $stable(flashWdata);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data moved");
  property p_once;
    flashReq && flashInfo |-> flashAddr[22:6] == 17'h0_0000 && flashAddr[2:0] == 3'h0 && !flashWrite;
  endproperty
  a_once: assert property (p_once) else $error("info access outside field");
  property p_align;
    flashReq && !flashInfo |-> flashAddr[2:0] == 3'h0;
  endproperty
  a_align: assert property (p_align) else $error("misaligned array access");
  property p_range;
    flashReq && !flashInfo |-> flashAddr >= PF_BASE && flashAddr <= PF_TOP;
  endproperty
  a_range: assert property (p_range) else $error("array access outside map");
  property p_prot;
    flashWrite && protEnable |-> flashAddr < protLo || flashAddr > protHi;
  endproperty
  a_prot: assert property (p_prot) else $error("protected phrase written");
endmodule // pfcs_sequencer_props
bind pfcs_sequencer pfcs_sequencer_props #(.PF_BASE(PF_BASE), .PF_TOP(PF_TOP)) pfcs_sequencer_props_inst (
  .clk_sys, .nrst, .s_axi_arready, .s_axi_rvalid, .protEnable, .protLo, .protHi,
  .flashReq, .flashWrite, .flashInfo, .flashAddr, .flashWdata, .flashAck, .blockReadInvalid);
`default_nettype wire

//--- verif/pfcs_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfcs_regs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("BAD %0t value mismatch %h %h", $time, a, b); end end
module pfcs_sequencer_test;
  // ====
  // Stimulus and flash responder
  localparam [4:0] ST = `PFCS_OFS_STAT, PT = `PFCS_OFS_PTR, DT = `PFCS_OFS_DATA, DV = `PFCS_OFS_DIV;
  localparam [63:0] ONCEV = 64'hA4A4_A3A3_A2A2_A1A1;
  reg         clk_sys = 1'b0;
  reg         nrst = 1'b0;
  reg  [4:0]  s_axi_awaddr = 5'h00;
  reg         s_axi_awvalid = 1'b0;
  reg  [31:0] s_axi_wdata = 32'h0000_0000;
  reg         s_axi_wvalid = 1'b0;
  reg         s_axi_bready = 1'b1;
  reg  [4:0]  s_axi_araddr = 5'h00;
  reg         s_axi_arvalid = 1'b0;
  reg         s_axi_rready = 1'b1;
  reg  [2:0]  modeAllow = 3'h7;
  reg         protEnable = 1'b0;
  reg  [22:0] protLo = 23'h70_0000;
  reg  [22:0] protHi = 23'h70_FFFF;
  reg         flashAck = 1'b0;
  reg  [63:0] flashRdata = 64'h0000_0000_0000_0000;
  reg         flashErr = 1'b0;
  reg         flashFatal = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        flashReq, flashWrite, flashInfo, blockReadInvalid;
  wire [22:0] flashAddr;
  wire [63:0] flashWdata;
  reg  [1:0]  dly = 2'h0;
  reg         injErr = 1'b0;
  reg  [63:0] mem = `PFCS_ERASED;
  reg  [63:0] lastW = 64'h0000_0000_0000_0000;
  reg  [22:0] lastA = 23'h00_0000;
  integer     wrCnt = 0;
  integer     errors = 0;
  integer     cmp_count = 0;
  reg  [1:0]  rsp;
  reg  [31:0] rdv;
  reg  [15:0] sv [0:5];
  integer     k;
  pfcs_sequencer pfcs_sequencer_inst (.clk_sys, .nrst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .modeAllow, .protEnable, .protLo, .protHi, .flashReq, .flashWrite, .flashInfo, .flashAddr, .flashWdata,
    .flashAck, .flashRdata, .flashErr, .flashFatal, .blockReadInvalid);
  always #5 clk_sys = ~clk_sys;
  // Acks every fourth cycle so the request hold is exercised
  always @(posedge clk_sys)
  begin
    flashAck <= 1'b0;
    if (!blockReadInvalid) mem <= `PFCS_ERASED;
    if (flashReq && !flashAck)
    begin
      dly <= dly + 2'h1;
      if (dly == 2'h2)
      begin
        dly <= 2'h0;
        flashAck <= 1'b1;
        flashErr <= injErr;
        flashFatal <= injErr;
        flashRdata <= flashInfo ? ONCEV : mem;
        lastA <= flashAddr;
        if (flashWrite) mem <= flashWdata;
        if (flashWrite) lastW <= flashWdata;
        if (flashWrite) wrCnt <= wrCnt + 1;
      end
    end
  end
  // ====
  // Bus tasks and tests
  task wr(input [4:0] a, input [15:0] d);
    reg aw, w, b;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      b = 1'b0;
      while (!b)
      begin
        @(negedge clk_sys);
        aw = s_axi_awvalid & s_axi_awready;
        w = s_axi_wvalid & s_axi_wready;
        b = s_axi_bvalid;
        rsp = s_axi_bresp;
        @(posedge clk_sys);
        if (aw) s_axi_awvalid <= 1'b0;
        if (w) s_axi_wvalid <= 1'b0;
      end
    end
  endtask
  task rd(input [4:0] a);
    reg t, r;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      r = 1'b0;
      while (!r)
      begin
        @(negedge clk_sys);
        t = s_axi_arvalid & s_axi_arready;
        r = s_axi_rvalid;
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge clk_sys);
        if (t) s_axi_arvalid <= 1'b0;
      end
    end
  endtask
  task rchk(input [4:0] a, input [15:0] e);
    begin
      rd(a);
      `CHK(rdv, {16'h0000, e})
    end
  endtask
  task ld(input [15:0] a, b, c, d, e, f);
    begin
      sv[0] = a; sv[1] = b; sv[2] = c; sv[3] = d; sv[4] = e; sv[5] = f;
    end
  endtask
  // Loads slots 0..n, leaves the pointer at n, launches, waits, checks status
  task go(input [2:0] n, input [7:0] e);
    integer i;
    begin
      for (i = 0; i <= n; i++)
      begin
        wr(PT, i[15:0]);
        wr(DT, sv[i]);
      end
      wr(ST, 16'h0080);
      i = 0;
      rd(ST);
      while (!rdv[7] && i < 60)
      begin
        rd(ST);
        i++;
      end
      `CHK(rdv[7:0], e)
      wr(ST, 16'h0030);
      $display("test end status %h", e);
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Whole sequence needs about 650 cycles
  initial
  begin
    #200000;
    errors++;
    finish_test;
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rchk(ST, 16'h0080);
    rchk(DV, 16'h0000);
    ld(16'h0661, 16'h0010, 16'h1111, 16'h2222, 16'h3333, 16'h4444);
    go(3'h5, 8'hA0);
    wr(DV, 16'h0005);
    `CHK(rsp, 2'h0)
    rchk(DV, 16'h0085);
    go(3'h5, 8'h80);
    `CHK(lastW, 64'h4444_3333_2222_1111)
    `CHK(lastA, 23'h61_0010)
    go(3'h4, 8'hA0);
    sv[1] = 16'h0012;
    go(3'h5, 8'hA0);
    ld(16'h0620, 16'h0010, 16'h1111, 16'h2222, 16'h3333, 16'h4444);
    go(3'h5, 8'hA0);
    sv[0] = 16'h0670;
    protEnable <= 1'b1;
    go(3'h5, 8'h90);
    protEnable <= 1'b0;
    modeAllow <= 3'h3;
    go(3'h5, 8'hA0);
    modeAllow <= 3'h7;
    sv[0] = 16'h0561;
    go(3'h5, 8'hA0);
    `CHK(wrCnt, 1)
    // Fresh erased phrase well below a live protected window
    sv[0] = 16'h0661;
    sv[1] = 16'h0018;
    protEnable <= 1'b1;
    injErr <= 1'b1;
    go(3'h5, 8'h83);
    injErr <= 1'b0;
    protEnable <= 1'b0;
    ld(16'h0361, 16'hFFF8, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
    go(3'h2, 8'h80);
    sv[2] = 16'h0002;
    go(3'h2, 8'hA0);
    go(3'h1, 8'hA0);
    sv[1] = 16'h0000;
    sv[2] = 16'h0003;
    injErr <= 1'b1;
    go(3'h2, 8'h83);
    injErr <= 1'b0;
    ld(16'h0400, 16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    go(3'h1, 8'h80);
    `CHK(lastA, 23'h00_0018)
    for (k = 2; k < 6; k++)
    begin
      wr(PT, k[15:0]);
      rchk(DT, ONCEV[(k - 2) * 16 +: 16]);
    end
    go(3'h2, 8'hA0);
    sv[1] = 16'h0008;
    go(3'h1, 8'hA0);
    sv[1] = 16'h0007;
    go(3'h1, 8'h80);
    rd(5'h10);
    `CHK(rsp, 2'h2)
    wr(5'h14, 16'h0000);
    `CHK(rsp, 2'h2)
    finish_test;
  end
endmodule // pfcs_sequencer_test
`default_nettype wire
